// ---- standby_wake_sequencer_map.vh ----
// Purpose: constants for the standby and wake sequencer
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes: definitions only
`ifndef STANDBY_WAKE_SEQUENCER_MAP_VH
`define STANDBY_WAKE_SEQUENCER_MAP_VH

// register byte offsets
`define SYSCTL_OFFSET 8'h00
`define DIVCTL_OFFSET 8'h04
`define STATUS_OFFSET 8'h08
`define COMMAND_OFFSET 8'h0C

// system_control_reg fields
`define SYSCTL_SOFT_HW_STANDBY_PIN_N 7
`define SYSCTL_WAIT_MSB 6
`define SYSCTL_WAIT_LSB 4
`define SYSCTL_NMI_EDGE 2
`define SYSCTL_RAM_EN 0
`define SYSCTL_RESET 8'h01

// divide_control_reg fields
`define DIVCTL_MSB 1
`define DIVCTL_LSB 0
`define DIVCTL_RESET 2'h0

// command register fields
`define CMD_SLEEP 0

// wait select codes
`define WAIT_SEL_ILLEGAL 3'h7

// settling waits in states of the divided clock
`define WAIT_STATES_0 22'h00_2000
`define WAIT_STATES_1 22'h00_4000
`define WAIT_STATES_2 22'h00_8000
`define WAIT_STATES_3 22'h01_0000
`define WAIT_STATES_4 22'h02_0000
`define WAIT_STATES_5 22'h04_0000
`define WAIT_STATES_6 22'h00_0400

// sequencer states
`define ST_RUN 3'h0
`define ST_SOFT_HW_STANDBY_PIN_N 3'h1
`define ST_SETTLE 3'h2
`define ST_HW_HW_STANDBY_PIN_N 3'h3
`define ST_RESET_HOLD 3'h4

`endif

// ---- pin_sync.v ----
// Purpose: two-flop synchroniser for the three pin inputs
// Assumes: pins are asynchronous to MCLK
// Notes: reset loads fixed idle-high values so reset does not fake an edge
`timescale 1ns/1ps
module pin_sync (
  input wire clk,
  input wire rst_n,
  input wire [2:0] pin,
  output reg [2:0] pin_sync_out
);

  reg [2:0] stage1;

  // stage1 is read only by the second flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 3'h7;
      pin_sync_out <= 3'h7;
    end else begin
      stage1 <= pin;
      pin_sync_out <= stage1;
    end
  end

endmodule

// ---- standby_wake_sequencer.v ----
// Purpose: power-down sequencer for software and hardware standby
// Assumes: MCLK at 50 MHz, pins asynchronous and synchronised inside, APB slave for registers
// Notes: long settle counts are parameters so a simulation can shorten them
//
// Function
// - settle wait chosen by three-bit select; code 111 is illegal
// - wait counted in divided-clock states; each divide step doubles it
// - nmi edge select: 0 detects falling edge, 1 rising edge
// - with rising edge selected, leave soft standby on next nmi rise
// - during soft standby all ports hold their present state
// - standby pin low enters hardware standby at once from any state
// - hardware standby halts everything and resets all but ram
// - all ports are high impedance throughout hardware standby
// - standby pin high while reset low restarts the oscillator
// - reset release after hardware standby starts reset handling
// - sleep with soft standby select set enters software standby
// - wake starts oscillator, gates clock until wait ends, then interrupt
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "standby_wake_sequencer_map.vh"
module standby_wake_sequencer #(
  parameter [21:0] WAIT_STATES_0 = `WAIT_STATES_0,
  parameter [21:0] WAIT_STATES_1 = `WAIT_STATES_1,
  parameter [21:0] WAIT_STATES_2 = `WAIT_STATES_2,
  parameter [21:0] WAIT_STATES_3 = `WAIT_STATES_3,
  parameter [21:0] WAIT_STATES_4 = `WAIT_STATES_4,
  parameter [21:0] WAIT_STATES_5 = `WAIT_STATES_5,
  parameter [21:0] WAIT_STATES_6 = `WAIT_STATES_6
) (
  input wire MCLK,
  input wire RSTN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire NMI,
  input wire HW_STANDBY_PIN_N,
  input wire RES_N,
  output reg OSC_EN,
  output reg CLOCK_EN,
  output reg CPU_HALT,
  output reg PERIPH_HALT,
  output reg MODULE_RESET_N,
  output reg PORT_HOLD,
  output reg PORT_HIZ,
  output reg RAM_ENABLE,
  output reg NMI_EVENT,
  output reg RESET_EXC,
  output reg INT_EXC
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [2:0] pins;
  wire nmi_s;
  wire hw_standby_pin_n_n_s;
  wire res_n_s;

  pin_sync u_sync (
    .clk(MCLK),
    .rst_n(RSTN),
    .pin({NMI, HW_STANDBY_PIN_N, RES_N}),
    .pin_sync_out(pins)
  );

  assign nmi_s = pins[2];
  assign hw_standby_pin_n_n_s = pins[1];
  assign res_n_s = pins[0];

  ////////////////////////////////////////////////////////////////////////
  // settle terminal count

  // cycles of MCLK for a select and divide pair
  function [21:0] settle_term;
    input [2:0] sel;
    input [1:0] div;
    reg [21:0] base;
    begin
      case (sel)
        3'h0: base = WAIT_STATES_0;
        3'h1: base = WAIT_STATES_1;
        3'h2: base = WAIT_STATES_2;
        3'h3: base = WAIT_STATES_3;
        3'h4: base = WAIT_STATES_4;
        3'h5: base = WAIT_STATES_5;
        3'h6: base = WAIT_STATES_6;
        default: base = WAIT_STATES_6;
      endcase
      // one divided-clock state is 2**div cycles of MCLK
      settle_term = base << div;
    end
  endfunction

  // status word: bit4 refused select, bit3 settle done, bits 2:0 state
  function [31:0] status_word;
    input illegal;
    input done;
    input [2:0] st;
    begin
      status_word = {27'h000_0000, illegal, done, st};
    end
  endfunction

  // soft standby or settling: ports held and modules kept out of reset
  function held_state;
    input [2:0] st;
    begin
      held_state = (st == `ST_SOFT_HW_STANDBY_PIN_N) || (st == `ST_SETTLE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state and registers

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] sysctl;
  reg [1:0] divctl;
  reg [21:0] settle_cnt;
  reg [21:0] settle_last;
  reg nmi_prev;
  reg sleep_req;
  reg settle_done;
  reg illegal_write;

  wire apb_setup;
  wire apb_done;
  wire wr_done;
  wire nmi_rise;
  wire nmi_fall;
  wire nmi_edge;
  wire hit_sysctl;
  wire hit_divctl;
  wire hit_status;
  wire hit_command;
  wire hit_any;
  wire [2:0] wait_sel;

  assign apb_setup = PSEL & PENABLE & ~PREADY;
  assign apb_done = PSEL & PENABLE & PREADY;
  assign wr_done = apb_done & PWRITE;
  assign hit_sysctl = (PADDR == `SYSCTL_OFFSET);
  assign hit_divctl = (PADDR == `DIVCTL_OFFSET);
  assign hit_status = (PADDR == `STATUS_OFFSET);
  assign hit_command = (PADDR == `COMMAND_OFFSET);
  assign hit_any = hit_sysctl | hit_divctl | hit_status | hit_command;
  assign wait_sel = sysctl[`SYSCTL_WAIT_MSB:`SYSCTL_WAIT_LSB];

  assign nmi_rise = nmi_s & ~nmi_prev;
  assign nmi_fall = ~nmi_s & nmi_prev;
  // edge select picks which transition counts
  assign nmi_edge = sysctl[`SYSCTL_NMI_EDGE] ? nmi_rise : nmi_fall;

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      nmi_prev <= 1'b1;
    end else begin
      nmi_prev <= nmi_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always @* begin
    next_state = state;
    case (state)
      `ST_RUN: begin
        if (!res_n_s) begin
          next_state = `ST_RESET_HOLD;
        end else if (sleep_req && sysctl[`SYSCTL_SOFT_HW_STANDBY_PIN_N]) begin
          next_state = `ST_SOFT_HW_STANDBY_PIN_N;
        end
      end
      `ST_SOFT_HW_STANDBY_PIN_N: begin
        if (!res_n_s) begin
          next_state = `ST_RESET_HOLD;
        end else if (nmi_edge) begin
          next_state = `ST_SETTLE;
        end
      end
      `ST_SETTLE: begin
        if (!res_n_s) begin
          next_state = `ST_RESET_HOLD;
        end else if (settle_done) begin
          next_state = `ST_RUN;
        end
      end
      `ST_HW_HW_STANDBY_PIN_N: begin
        if (hw_standby_pin_n_n_s) begin
          next_state = `ST_RESET_HOLD;
        end
      end
      `ST_RESET_HOLD: begin
        if (res_n_s) begin
          next_state = `ST_RUN;
        end
      end
      default: begin
        next_state = `ST_RESET_HOLD;
      end
    endcase
    // standby pin overrides every other transition
    if (!hw_standby_pin_n_n_s) begin
      next_state = `ST_HW_HW_STANDBY_PIN_N;
    end
  end

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= `ST_RESET_HOLD;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settle counter

  // terminal latched at wake so a register write mid-wait cannot move it
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      settle_cnt <= 22'h00_0000;
      settle_last <= 22'h00_0000;
      settle_done <= 1'b0;
    end else if (state == `ST_SOFT_HW_STANDBY_PIN_N && nmi_edge) begin
      settle_cnt <= 22'h00_0000;
      settle_last <= settle_term(wait_sel, divctl) - 22'h00_0001;
      settle_done <= 1'b0;
    end else if (state == `ST_SETTLE && !settle_done) begin
      settle_cnt <= settle_cnt + 22'h00_0001;
      settle_done <= (settle_cnt == settle_last - 22'h00_0001);
    end else begin
      settle_done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb registers

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sysctl <= `SYSCTL_RESET;
      divctl <= `DIVCTL_RESET;
      sleep_req <= 1'b0;
      illegal_write <= 1'b0;
    end else if (state == `ST_HW_HW_STANDBY_PIN_N) begin
      // everything but ram is reset in hardware standby
      sysctl <= `SYSCTL_RESET;
      divctl <= `DIVCTL_RESET;
      sleep_req <= 1'b0;
      illegal_write <= 1'b0;
    end else begin
      sleep_req <= wr_done & hit_command & PWDATA[`CMD_SLEEP];
      if (wr_done && hit_sysctl) begin
        sysctl[`SYSCTL_SOFT_HW_STANDBY_PIN_N] <= PWDATA[`SYSCTL_SOFT_HW_STANDBY_PIN_N];
        sysctl[`SYSCTL_NMI_EDGE] <= PWDATA[`SYSCTL_NMI_EDGE];
        sysctl[`SYSCTL_RAM_EN] <= PWDATA[`SYSCTL_RAM_EN];
        // the illegal code is refused and the old select kept
        if (PWDATA[`SYSCTL_WAIT_MSB:`SYSCTL_WAIT_LSB] == `WAIT_SEL_ILLEGAL) begin
          illegal_write <= 1'b1;
        end else begin
          sysctl[`SYSCTL_WAIT_MSB:`SYSCTL_WAIT_LSB] <=
            PWDATA[`SYSCTL_WAIT_MSB:`SYSCTL_WAIT_LSB];
          illegal_write <= 1'b0;
        end
      end
      if (wr_done && hit_divctl) begin
        divctl <= PWDATA[`DIVCTL_MSB:`DIVCTL_LSB];
      end
    end
  end

  // answer one cycle into the access phase
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup & ~hit_any;
      if (apb_setup && !PWRITE) begin
        if (hit_sysctl) begin
          PRDATA <= {24'h00_0000, sysctl};
        end else if (hit_divctl) begin
          PRDATA <= {30'h0000_0000, divctl};
        end else if (hit_status) begin
          PRDATA <= status_word(illegal_write, settle_done, state);
        end else begin
          PRDATA <= 32'h0000_0000;
        end
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, decoded from the next state

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      OSC_EN <= 1'b1;
      CLOCK_EN <= 1'b1;
      CPU_HALT <= 1'b1;
      PERIPH_HALT <= 1'b1;
      MODULE_RESET_N <= 1'b0;
      PORT_HOLD <= 1'b0;
      PORT_HIZ <= 1'b0;
      RAM_ENABLE <= 1'b1;
      NMI_EVENT <= 1'b0;
      RESET_EXC <= 1'b0;
      INT_EXC <= 1'b0;
    end else begin
      // oscillator off only in the two standby states
      OSC_EN <= (next_state != `ST_HW_HW_STANDBY_PIN_N) &&
        (next_state != `ST_SOFT_HW_STANDBY_PIN_N);
      // clock withheld until the settle wait ends
      CLOCK_EN <= (next_state == `ST_RUN) ||
        (next_state == `ST_RESET_HOLD);
      CPU_HALT <= (next_state != `ST_RUN);
      PERIPH_HALT <= (next_state != `ST_RUN) &&
        (next_state != `ST_RESET_HOLD);
      MODULE_RESET_N <= (next_state == `ST_RUN) || held_state(next_state);
      PORT_HOLD <= held_state(next_state);
      PORT_HIZ <= (next_state == `ST_HW_HW_STANDBY_PIN_N);
      RAM_ENABLE <= sysctl[`SYSCTL_RAM_EN] & (next_state != `ST_HW_HW_STANDBY_PIN_N);
      NMI_EVENT <= (state == `ST_RUN) && nmi_edge && (next_state == `ST_RUN);
      RESET_EXC <= (state == `ST_RESET_HOLD) && (next_state == `ST_RUN);
      INT_EXC <= (state == `ST_SETTLE) && (next_state == `ST_RUN);
    end
  end

endmodule

// ---- standby_wake_monitor.sv ----
// Purpose: concurrent checks on the standby and wake sequencer ports
// Assumes: one clock, RSTN asynchronous active low
// Notes: windows allow for the two-flop pin synchroniser
`timescale 1ns/1ps
module standby_wake_monitor (
  input wire MCLK,
  input wire RSTN,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire HW_STANDBY_PIN_N,
  input wire RES_N,
  input wire OSC_EN,
  input wire CLOCK_EN,
  input wire CPU_HALT,
  input wire PERIPH_HALT,
  input wire MODULE_RESET_N,
  input wire PORT_HOLD,
  input wire PORT_HIZ,
  input wire RAM_ENABLE,
  input wire NMI_EVENT,
  input wire RESET_EXC,
  input wire INT_EXC
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_hw_standby_pin_n_held;
    (!HW_STANDBY_PIN_N) [*5];
  endsequence
  sequence s_access_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  a_hw_standby_pin_n_forces_hiz: assert property (s_hw_standby_pin_n_held |-> PORT_HIZ)
    else $error("standby pin low, ports not hi-z");
  a_hiz_halts_all: assert property (PORT_HIZ |-> !OSC_EN && !MODULE_RESET_N && CPU_HALT
    && PERIPH_HALT && !RAM_ENABLE) else $error("hw standby outputs wrong");
  a_osc_restarts: assert property ($rose(HW_STANDBY_PIN_N) && !RES_N |-> ##[1:8] OSC_EN)
    else $error("oscillator not restarted");
  a_reset_handling: assert property ($rose(RES_N) && HW_STANDBY_PIN_N |-> ##[1:8] RESET_EXC)
    else $error("no reset handling after release");
  a_hold_gates_clock: assert property (PORT_HOLD |-> !CLOCK_EN && CPU_HALT && PERIPH_HALT
    && !PORT_HIZ) else $error("soft standby outputs wrong");
  a_int_after_settle: assert property (INT_EXC |-> $past(PORT_HOLD))
    else $error("interrupt handling without settle");
  // one wait state is the designer's fixed answer time
  a_apb_one_wait: assert property (s_access_wait |=> PREADY)
    else $error("apb answer late");
  a_nmi_running: assert property (NMI_EVENT |-> !CPU_HALT)
    else $error("nmi event while halted");
endmodule
bind standby_wake_sequencer standby_wake_monitor u_mon (
  .MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .HW_STANDBY_PIN_N(HW_STANDBY_PIN_N), .RES_N(RES_N), .OSC_EN(OSC_EN), .CLOCK_EN(CLOCK_EN),
  .CPU_HALT(CPU_HALT), .PERIPH_HALT(PERIPH_HALT), .MODULE_RESET_N(MODULE_RESET_N),
  .PORT_HOLD(PORT_HOLD), .PORT_HIZ(PORT_HIZ), .RAM_ENABLE(RAM_ENABLE),
  .NMI_EVENT(NMI_EVENT), .RESET_EXC(RESET_EXC), .INT_EXC(INT_EXC)
);

// ---- power_ctrl_model.sv ----
// Purpose: external power controller driving nmi, standby and reset pins
// Assumes: pins idle high through pull-ups
// Notes: every change lands just after a rising edge
`timescale 1ns/1ps
module power_ctrl_model (
  input wire clk,
  output logic nmi,
  output logic hw_standby_pin_n_n,
  output logic res_n
);
  // mode pins are not modelled, so they never change in hw standby
  initial begin
    nmi = 1'b1;
    hw_standby_pin_n_n = 1'b1;
    res_n = 1'b1;
  end
  task set_nmi(input logic v);
    @(posedge clk);
    nmi <= v;
  endtask
  task enter_hw;
    @(posedge clk);
    res_n <= 1'b0;
    repeat (4) @(posedge clk);
    hw_standby_pin_n_n <= 1'b0;
  endtask
  // settle is the caller's choice; too short would break oscillator startup
  task leave_hw(input int settle);
    @(posedge clk);
    hw_standby_pin_n_n <= 1'b1;
    repeat (settle) @(posedge clk);
    res_n <= 1'b1;
  endtask
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for the standby and wake sequencer
// Assumes: shortened settle counts, pins from the power controller model
// Notes: settle windows allow for the pin synchroniser
`timescale 1ns/1ps
`include "standby_wake_sequencer_map.vh"
module testbench;
  // shortened settle counts, in the order of the wait select codes
  localparam logic [21:0] WS [7] = '{22'h00_0008, 22'h00_0010, 22'h00_0020, 22'h00_0040,
    22'h00_0080, 22'h00_0100, 22'h00_0004};
  logic MCLK, RSTN, PSEL, PENABLE, PWRITE, er;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, rd;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, NMI, HW_STANDBY_PIN_N, RES_N, OSC_EN, CLOCK_EN, CPU_HALT, PERIPH_HALT;
  wire MODULE_RESET_N, PORT_HOLD, PORT_HIZ, RAM_ENABLE, NMI_EVENT, RESET_EXC, INT_EXC;
  wire [3:0] watch = {RESET_EXC, INT_EXC, NMI_EVENT, PORT_HIZ};
  int err_count = 0;
  int comparisons = 0;
  int n, i;
  ////////////////////////////////////////////////////////////////////////////
  standby_wake_sequencer #(.WAIT_STATES_0(WS[0]), .WAIT_STATES_1(WS[1]),
    .WAIT_STATES_2(WS[2]), .WAIT_STATES_3(WS[3]), .WAIT_STATES_4(WS[4]),
    .WAIT_STATES_5(WS[5]), .WAIT_STATES_6(WS[6])) u_dut (
    .MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .NMI(NMI), .HW_STANDBY_PIN_N(HW_STANDBY_PIN_N), .RES_N(RES_N), .OSC_EN(OSC_EN),
    .CLOCK_EN(CLOCK_EN), .CPU_HALT(CPU_HALT), .PERIPH_HALT(PERIPH_HALT),
    .MODULE_RESET_N(MODULE_RESET_N), .PORT_HOLD(PORT_HOLD), .PORT_HIZ(PORT_HIZ),
    .RAM_ENABLE(RAM_ENABLE), .NMI_EVENT(NMI_EVENT), .RESET_EXC(RESET_EXC), .INT_EXC(INT_EXC));
  power_ctrl_model u_pwr (.clk(MCLK), .nmi(NMI), .hw_standby_pin_n_n(HW_STANDBY_PIN_N), .res_n(RES_N));
  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    chk(PREADY, 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wait_bit(input int b, input int lim);
    n = 0;
    while (watch[b] !== 1'b1 && n < lim) begin
      @(posedge MCLK);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  initial begin
    repeat (10000) @(posedge MCLK);
    err_count++;
    give_verdict;
  end
  initial begin
    RSTN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    repeat (10) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (8) @(posedge MCLK);
    apb(0, `SYSCTL_OFFSET, 0);
    chk(rd, `SYSCTL_RESET);
    apb(0, 8'h10, 0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    // illegal code must leave the earlier select in place
    apb(1, `SYSCTL_OFFSET, 32'h0000_0021);
    apb(1, `SYSCTL_OFFSET, 32'h0000_0071);
    apb(0, `SYSCTL_OFFSET, 0);
    chk(rd, 32'h0000_0021);
    apb(0, `STATUS_OFFSET, 0);
    chk(rd[4], 1'b1);
    for (i = 0; i < 2; i++) begin
      apb(1, `SYSCTL_OFFSET, 32'h0000_0001 | (i << 2));
      u_pwr.set_nmi(1'b0);
      wait_bit(1, 10);
      chk(n < 10, i == 0);
      u_pwr.set_nmi(1'b1);
      wait_bit(1, 10);
      chk(n < 10, i == 1);
    end
    // external clock assumed, so every legal select and divide is allowed
    // a crystal would need select 4 with divide 2 or longer for 7 ms at 50 MHz
    for (i = 0; i < 7; i++) begin
      apb(1, `DIVCTL_OFFSET, i % 4);
      apb(1, `SYSCTL_OFFSET, 32'h0000_0085 | (i << 4));
      apb(1, `COMMAND_OFFSET, 32'h0000_0001);
      u_pwr.set_nmi(1'b0);
      repeat (8) @(posedge MCLK);
      chk({PORT_HOLD, OSC_EN, PERIPH_HALT}, 3'h5);
      u_pwr.set_nmi(1'b1);
      wait_bit(2, 3000);
      chk(n >= (WS[i] << (i % 4)) && n <= (WS[i] << (i % 4)) + 8, 1'b1);
      repeat (2) @(posedge MCLK);
      chk({CLOCK_EN, CPU_HALT, PERIPH_HALT, PORT_HOLD}, 4'h8);
    end
    apb(1, `SYSCTL_OFFSET, 32'h0000_0020);
    u_pwr.enter_hw;
    wait_bit(0, 20);
    chk({PORT_HIZ, RAM_ENABLE, MODULE_RESET_N}, 3'h4);
    apb(1, `SYSCTL_OFFSET, 32'h0000_0040);
    apb(0, `SYSCTL_OFFSET, 0);
    chk(rd, `SYSCTL_RESET);
    fork
      u_pwr.leave_hw(30);
      begin
        repeat (10) @(posedge MCLK);
        chk({OSC_EN, PORT_HIZ, CPU_HALT}, 3'h5);
      end
    join
    wait_bit(3, 20);
    chk(n < 20, 1'b1);
    repeat (2) @(posedge MCLK);
    chk(CPU_HALT, 1'b0);
    give_verdict;
  end
endmodule
